// ==== src/pretune_kick_ctrl.sv ====
/*
 * Pretune DAC latch, delay-compensation DAC latch, sweep-disable switch and
 * one-shot retrace kick pulse generator, all in the system clock domain.
 * Assumes the decoded low-true bus strobes and the data bus are synchronous
 * to clk_i and that data is valid during the strobe's first low cycle.
 */
// Notes on behaviour
// - Pretune write latches bus bits 1..12 into the 12-bit pretune register.
// - Pretune strobe comes from channel 3/2; latching happens only on it.
// - Sweep enable low grounds the sweep ramp summing input.
// - Compensation write at channel 5/3 loads the 8-bit compensation register.
// - Kick output is active low, asserted only for the programmed width.
// - Width write loads width, drops any kick and clears elapsed time.
// - Trigger starts the kick; block ends it itself after the duration.
// - Kick duration in ms equals written number / 512 times 34.
// - Kick width register takes bus bits 1..8, half the written number.
`timescale 1ns/1ns
`default_nettype none

module pretune_kick_ctrl #(
    parameter int STEP_CYCLES = pretune_kick_pkg::KICK_STEP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [pretune_kick_pkg::BUS_W-1:0] data_bus_i,
    input wire logic pretune_write_strobe_n_i,
    input wire logic comp_write_strobe_n_i,
    input wire logic kick_width_write_n_i,
    input wire logic kick_trigger_n_i,
    input wire logic sweep_enable_level_i,
    output logic [pretune_kick_pkg::PRETUNE_W-1:0] pretune_dac_code_o,
    output logic [pretune_kick_pkg::COMP_W-1:0] delay_comp_code_o,
    output logic [pretune_kick_pkg::KICK_W-1:0] kick_width_code_o,
    output logic kick_n_o,
    output logic sweep_ramp_ground_o
);

    typedef struct packed {
        logic [pretune_kick_pkg::PRETUNE_W-1:0] pretune;
        logic [pretune_kick_pkg::COMP_W-1:0] comp;
        logic [pretune_kick_pkg::KICK_W-1:0] width;
        pretune_kick_pkg::kick_state_e state;
        logic [pretune_kick_pkg::TICK_W-1:0] tick;
        logic [pretune_kick_pkg::KICK_W-1:0] steps;
        logic kick_n;
        logic ground;
        logic pre_prev_n;
        logic comp_prev_n;
        logic width_prev_n;
        logic trig_prev_n;
    } state_s;

    localparam logic [pretune_kick_pkg::TICK_W-1:0] TICK_LAST =
        pretune_kick_pkg::TICK_W'(STEP_CYCLES - 1);
    localparam logic [pretune_kick_pkg::TICK_W-1:0] TICK_ZERO = 16'h0000;
    localparam logic [pretune_kick_pkg::TICK_W-1:0] TICK_ONE = 16'h0001;
    localparam logic [pretune_kick_pkg::KICK_W-1:0] STEP_ONE = 8'h01;
    localparam logic [pretune_kick_pkg::KICK_W-1:0] STEP_ZERO = 8'h00;

    state_s st_r;
    state_s st_nxt;

    // Strobe edges: each bus cycle acts once, however long the strobe is low
    logic pre_fall;
    logic comp_fall;
    logic width_fall;
    logic trig_fall;
    logic tick_end;

    assign pre_fall = st_r.pre_prev_n & ~pretune_write_strobe_n_i;
    assign comp_fall = st_r.comp_prev_n & ~comp_write_strobe_n_i;
    assign width_fall = st_r.width_prev_n & ~kick_width_write_n_i;
    assign trig_fall = st_r.trig_prev_n & ~kick_trigger_n_i;
    assign tick_end = (st_r.tick == TICK_LAST);

    // Next-state logic for latches and kick one-shot
    always_comb begin
        st_nxt = st_r;
        st_nxt.pre_prev_n = pretune_write_strobe_n_i;
        st_nxt.comp_prev_n = comp_write_strobe_n_i;
        st_nxt.width_prev_n = kick_width_write_n_i;
        st_nxt.trig_prev_n = kick_trigger_n_i;
        // Registered so the switch output comes straight from a flop
        st_nxt.ground = ~sweep_enable_level_i;
        if (pre_fall) begin
            // Bit 0 dropped: DAC sees half of the processor's number
            st_nxt.pretune = data_bus_i[pretune_kick_pkg::PRETUNE_MSB:
                                        pretune_kick_pkg::PRETUNE_LSB];
        end
        if (comp_fall) begin
            st_nxt.comp = data_bus_i[pretune_kick_pkg::COMP_MSB:
                                     pretune_kick_pkg::COMP_LSB];
        end
        if (width_fall) begin
            // A width write wins over a trigger in the same cycle
            st_nxt.width = data_bus_i[pretune_kick_pkg::KICK_MSB:
                                      pretune_kick_pkg::KICK_LSB];
            st_nxt.state = pretune_kick_pkg::KICK_IDLE;
            st_nxt.kick_n = 1'b1;
            st_nxt.tick = TICK_ZERO;
            st_nxt.steps = STEP_ZERO;
        end else begin
            unique case (st_r.state)
                pretune_kick_pkg::KICK_IDLE: begin
                    // Zero width gives no pulse at all
                    if (trig_fall && st_r.width != STEP_ZERO) begin
                        st_nxt.state = pretune_kick_pkg::KICK_ACTIVE;
                        st_nxt.kick_n = 1'b0;
                        st_nxt.tick = TICK_ZERO;
                        st_nxt.steps = STEP_ZERO;
                    end
                end
                pretune_kick_pkg::KICK_ACTIVE: begin
                    // Triggers are not looked at here, so a retrigger cannot stretch it
                    if (tick_end) begin
                        st_nxt.tick = TICK_ZERO;
                        st_nxt.steps = st_r.steps + STEP_ONE;
                        if (st_r.steps + STEP_ONE == st_r.width) begin
                            st_nxt.state = pretune_kick_pkg::KICK_IDLE;
                            st_nxt.kick_n = 1'b1;
                            st_nxt.steps = STEP_ZERO;
                        end
                    end else begin
                        st_nxt.tick = st_r.tick + TICK_ONE;
                    end
                end
                default: begin
                    st_nxt.state = pretune_kick_pkg::KICK_IDLE;
                    st_nxt.kick_n = 1'b1;
                end
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.pretune <= pretune_kick_pkg::PRETUNE_RST;
            st_r.comp <= pretune_kick_pkg::COMP_RST;
            st_r.width <= pretune_kick_pkg::KICK_RST;
            st_r.state <= pretune_kick_pkg::KICK_IDLE;
            st_r.tick <= TICK_ZERO;
            st_r.steps <= STEP_ZERO;
            st_r.kick_n <= 1'b1;
            st_r.ground <= 1'b1;
            st_r.pre_prev_n <= 1'b1;
            st_r.comp_prev_n <= 1'b1;
            st_r.width_prev_n <= 1'b1;
            st_r.trig_prev_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign pretune_dac_code_o = st_r.pretune;
    assign delay_comp_code_o = st_r.comp;
    assign kick_width_code_o = st_r.width;
    assign kick_n_o = st_r.kick_n;
    assign sweep_ramp_ground_o = st_r.ground;

    // Checks
    a_pretune_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        pre_fall |=> pretune_dac_code_o == $past(data_bus_i[pretune_kick_pkg::PRETUNE_MSB:
                                                             pretune_kick_pkg::PRETUNE_LSB]))
        else $error("pretune code not captured from bus bits 1 to 12");

    a_pretune_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !pre_fall ##1 !rst_i |-> $stable(pretune_dac_code_o))
        else $error("pretune code changed without its strobe");

    a_comp_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_fall |=> delay_comp_code_o == $past(data_bus_i[pretune_kick_pkg::COMP_MSB:
                                                            pretune_kick_pkg::COMP_LSB]))
        else $error("compensation code not captured");

    a_width_load: assert property (@(posedge clk_i) disable iff (rst_i)
        width_fall |=> kick_width_code_o == $past(data_bus_i[pretune_kick_pkg::KICK_MSB:
                                                             pretune_kick_pkg::KICK_LSB])
                       && kick_n_o)
        else $error("width write did not load width and drop kick");

    a_width_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        width_fall ##1 (kick_trigger_n_i && !width_fall) [*3] |-> kick_n_o)
        else $error("kick asserted after width write without trigger");

    a_sweep_ground: assert property (@(posedge clk_i) disable iff (rst_i)
        !sweep_enable_level_i |=> sweep_ramp_ground_o)
        else $error("sweep ramp not grounded while sweep disabled");

    a_kick_start: assert property (@(posedge clk_i) disable iff (rst_i)
        trig_fall && kick_n_o && !width_fall && kick_width_code_o != 8'h00
        |=> !kick_n_o)
        else $error("trigger did not start the kick");

    a_kick_only_width: assert property (@(posedge clk_i) disable iff (rst_i)
        !kick_n_o |-> kick_width_code_o != 8'h00 && st_r.steps < kick_width_code_o)
        else $error("kick asserted beyond its programmed width");

    a_kick_end: assert property (@(posedge clk_i) disable iff (rst_i)
        !kick_n_o && tick_end && st_r.steps + STEP_ONE == kick_width_code_o && !width_fall
        |=> kick_n_o)
        else $error("kick did not end after programmed duration");

    a_kick_retrig: assert property (@(posedge clk_i) disable iff (rst_i)
        !kick_n_o && trig_fall && !width_fall && !tick_end
        |=> st_r.tick == $past(st_r.tick) + TICK_ONE)
        else $error("retrigger disturbed an active kick");

    a_reset_clear: assert property (@(posedge clk_i)
        rst_i |=> pretune_dac_code_o == pretune_kick_pkg::PRETUNE_RST
                  && delay_comp_code_o == pretune_kick_pkg::COMP_RST
                  && kick_width_code_o == pretune_kick_pkg::KICK_RST && kick_n_o)
        else $error("reset did not clear registers and kick");

endmodule : pretune_kick_ctrl

`default_nettype wire

// ==== src/pretune_kick_pkg.sv ====
/*
 * Constants for the oscillator pretune and retrace kick control block:
 * data bus field positions, reset values, kick state codes and kick timing.
 * Assumes a 250 MHz system clock; all timing counts derive from its period.
 */
package pretune_kick_pkg;

    // Instrument data bus
    localparam int BUS_W = 16;

    // Pretune latch takes bus bits 1..12
    localparam int PRETUNE_W = 12;
    localparam int PRETUNE_LSB = 1;
    localparam int PRETUNE_MSB = 12;

    // Compensation code takes bus bits 0..7
    localparam int COMP_W = 8;
    localparam int COMP_LSB = 0;
    localparam int COMP_MSB = 7;

    // Kick width code takes bus bits 1..8
    localparam int KICK_W = 8;
    localparam int KICK_LSB = 1;
    localparam int KICK_MSB = 8;

    // Reset values
    localparam logic [PRETUNE_W-1:0] PRETUNE_RST = 12'h000;
    localparam logic [COMP_W-1:0] COMP_RST = 8'h00;
    localparam logic [KICK_W-1:0] KICK_RST = 8'h00;

    // Kick timing: duration = written number / 512 * 34 ms
    localparam int CLK_PERIOD_NS = 4;
    localparam int KICK_SPAN_NS = 34_000_000;
    localparam int KICK_NUMBER_DIV = 512;
    // Stored code is half the written number, so one code step spans 2/512 of 34 ms
    localparam int KICK_CODE_DIV = KICK_NUMBER_DIV / 2;
    // Shortest-time rounding: round down
    localparam int KICK_STEP_CYCLES = KICK_SPAN_NS / (KICK_CODE_DIV * CLK_PERIOD_NS);
    localparam int TICK_W = 16;

    // Kick state, one-hot
    typedef enum logic [1:0] {
        KICK_IDLE = 2'h1,
        KICK_ACTIVE = 2'h2
    } kick_state_e;

endpackage : pretune_kick_pkg

// ==== bench/proc_model.sv ====
/* Processor-side model: decoded low-true write strobes, data bus, sweep level.
   Assumes it shares the control block's clock and acts just after each edge. */
`timescale 1ns/1ns
`default_nettype none
module proc_model (
    input wire logic clk_i,
    output logic [pretune_kick_pkg::BUS_W-1:0] data_bus_o,
    output logic [3:0] strobe_n_o,
    output logic sweep_enable_level_o
);
    // Idle state: all strobes high, bus shows a pattern, ramp switched out
    initial begin
        data_bus_o = 16'h5A5A;
        strobe_n_o = 4'hF;
        sweep_enable_level_o = 1'b0;
    end

    // Strobe 0 pretune (3/2), 1 comp (5/3), 2 width (5/1), 3 trigger (3/0)
    task automatic write_strobe(input int sel, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        data_bus_o = d;
        strobe_n_o[sel] = 1'b0;
        @(posedge clk_i);
        #1;
        strobe_n_o[sel] = 1'b1;
        data_bus_o = ~d; // Released bus must not keep the word
    endtask : write_strobe

    // Word is offset above 2.3 GHz times 1740; top usable offset is 4700 MHz
    task automatic tune(input int mhz_over);
        write_strobe(0, 16'((mhz_over * 1740) / 1000));
    endtask : tune

    // Ramp summed only for sweeps wider than 500 kHz
    task automatic sweep(input logic sweeping, input int width_khz);
        @(posedge clk_i);
        #1;
        sweep_enable_level_o = sweeping && (width_khz > 500);
    endtask : sweep
endmodule : proc_model
`default_nettype wire

// ==== bench/tb.sv ====
/* Self-checking bench for the pretune and retrace kick control block.
   Assumes the processor model drives every strobe, the bus and the sweep level. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int STEP = 4; // Short step keeps kicks to at most 1020 cycles
    logic clk_i;
    logic rst_i;
    logic [15:0] data_bus;
    logic [3:0] strobe_n;
    logic sweep_en;
    logic [11:0] pretune_code;
    logic [7:0] comp_code;
    logic [7:0] width_code;
    logic kick_n;
    logic ramp_ground;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    pretune_kick_ctrl #(.STEP_CYCLES(STEP)) pretune_kick_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .data_bus_i(data_bus),
        .pretune_write_strobe_n_i(strobe_n[0]), .comp_write_strobe_n_i(strobe_n[1]),
        .kick_width_write_n_i(strobe_n[2]), .kick_trigger_n_i(strobe_n[3]),
        .sweep_enable_level_i(sweep_en), .pretune_dac_code_o(pretune_code),
        .delay_comp_code_o(comp_code), .kick_width_code_o(width_code),
        .kick_n_o(kick_n), .sweep_ramp_ground_o(ramp_ground));

    proc_model proc_model_inst (.clk_i(clk_i), .data_bus_o(data_bus),
        .strobe_n_o(strobe_n), .sweep_enable_level_o(sweep_en));

    // Clock and hang guard; run needs well under 3000 cycles
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic cmp_code(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_code

    task automatic cmp_len(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_len

    task automatic wr(input int sel, input logic [15:0] d);
        proc_model_inst.write_strobe(sel, d);
    endtask : wr

    // Counts remaining low cycles of the kick, bounded
    task automatic kick_len(output int len);
        len = 0;
        while (kick_n === 1'b0 && len < 2000) begin
            @(posedge clk_i);
            #1;
            len++;
        end
    endtask : kick_len

    task automatic t_registers();
        cmp_code(pretune_code, 16'h0000);
        cmp_code({comp_code, width_code}, 16'h0000);
        cmp_code({kick_n, ramp_ground}, 16'h0003);
        wr(0, 16'hFFFF);
        cmp_code(pretune_code, 16'h0FFF);
        proc_model_inst.tune(4700);
        cmp_code(pretune_code, 16'h0FF9);
        wr(0, 16'hE001);
        cmp_code(pretune_code, 16'h0000);
        cmp_code({comp_code, width_code}, 16'h0000);
        wr(1, 16'hABCD);
        cmp_code(comp_code, 16'h00CD);
        cmp_code(pretune_code, 16'h0000);
        $display("test registers done");
    endtask : t_registers

    task automatic t_sweep();
        proc_model_inst.sweep(1'b1, 501);
        @(posedge clk_i);
        #1;
        cmp_code(ramp_ground, 16'h0000);
        proc_model_inst.sweep(1'b0, 1000);
        @(posedge clk_i);
        #1;
        cmp_code(ramp_ground, 16'h0001);
        proc_model_inst.sweep(1'b1, 502);
        @(posedge clk_i);
        #1;
        cmp_code(ramp_ground, 16'h0000);
        proc_model_inst.sweep(1'b1, 500);
        @(posedge clk_i);
        #1;
        cmp_code(ramp_ground, 16'h0001);
        $display("test sweep done");
    endtask : t_sweep

    task automatic t_kick();
        wr(2, 16'h0006);
        cmp_code(width_code, 16'h0003);
        wr(3, 16'h0000);
        kick_len(n);
        cmp_len(n, 3 * STEP);
        wr(3, 16'h0000);
        repeat (3) @(posedge clk_i);
        wr(3, 16'h0000);
        kick_len(n);
        cmp_len(n, 3 * STEP - 5);
        wr(3, 16'h0000);
        repeat (2) @(posedge clk_i);
        wr(2, 16'h0004);
        cmp_code({width_code, 7'h00, kick_n}, 16'h0201);
        // Quiet trigger line after the width write, so the kick must stay off
        repeat (3) @(posedge clk_i);
        wr(3, 16'h0000);
        kick_len(n);
        cmp_len(n, 2 * STEP);
        $display("test kick done");
    endtask : t_kick

    task automatic t_bounds();
        wr(2, 16'h0000);
        wr(3, 16'h0000);
        @(posedge clk_i);
        #1;
        cmp_code(kick_n, 16'h0001);
        wr(2, 16'h01FE);
        cmp_code(width_code, 16'h00FF);
        wr(3, 16'h0000);
        kick_len(n);
        cmp_len(n, 255 * STEP);
        $display("test bounds done");
    endtask : t_bounds

    task automatic conclude();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // Reset for five cycles, then the scenarios in turn
    initial begin
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        t_registers();
        t_sweep();
        t_kick();
        t_bounds();
        conclude();
    end
endmodule : tb
`default_nettype wire
